/* File: include/cxp_pkg.sv */
// Package of constants and types for the coexistence priority block.
// Behaviour
// - RX high when tag exceeds RX threshold.
// - TX high when tag exceeds TX threshold.
// - Hold signalled priority for programmed duration.
// - Zero duration holds until enable drops.
// - Assert priority after programmed delay from enable.
// - Passive scan priority, bits 31:28, reset 3.
// - Non-connectable advertising priority, 27:24, reset 4.
// - Connectable advertising priority, 23:20, reset 8.
// - Active scan priority, bits 19:16, reset 9.
// - Initiating scan priority, 15:12, reset A.
// - Data channel priority, bits 11:8, reset D.
// - Link control priority, bits 7:4, reset E.
// - Connect request priority, bits 3:0, reset F.
// - Fallback priority, map B 31:28, reset 3.
// - Mode codes: 00, 01, 10 high-priority.
// - Priority indications raised only while enabled; the tag is driven always.
package cxp_pkg;

  // ****************************************************************
  // Register map, byte addresses on the bus.
  // ****************************************************************
  localparam logic [31:0] ADR_MODE_CTRL = 32'h4000_0100; // Modes, enable.
  localparam logic [31:0] ADR_TIMING = 32'h4000_0104; // Thresholds, timing.
  localparam logic [31:0] ADR_MAP_A = 32'h4000_0108; // Per-type priorities.
  localparam logic [31:0] ADR_MAP_B = 32'h4000_010C; // Fallback priority.
  localparam logic [31:0] ADR_STATUS = 32'h4000_0110; // Live state, read only.

  // Writable bits of each register; the rest read as zero.
  localparam logic [31:0] MODE_CTRL_MASK = 32'h0033_0001;
  localparam logic [31:0] TIMING_MASK = 32'h1F1F_7F7F;
  localparam logic [31:0] MAP_A_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] MAP_B_MASK = 32'hF000_0000;

  // Values after reset.
  localparam logic [31:0] MODE_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] MAP_A_RST = 32'h3489_ADEF;
  localparam logic [31:0] MAP_B_RST = 32'h3000_0000;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int COEXISTENCE_ENABLE_BIT = 0; // Coexistence enable.
  localparam int TX_MODE_LSB = 16; // Two bits.
  localparam int RX_MODE_LSB = 20; // Two bits.
  localparam int DELAY_LSB = 0; // Seven bits.
  localparam int DUR_LSB = 8; // Seven bits.
  localparam int TX_THR_LSB = 16; // Five bits.
  localparam int RX_THR_LSB = 24; // Five bits.
  localparam int PRIO_CONN_REQ_LSB = 0;
  localparam int PRIO_LINK_CTRL_LSB = 4;
  localparam int PRIO_DATA_LSB = 8;
  localparam int PRIO_INIT_SCAN_LSB = 12;
  localparam int PRIO_ACT_SCAN_LSB = 16;
  localparam int PRIO_CONN_ADV_LSB = 20;
  localparam int PRIO_NONCONN_ADV_LSB = 24;
  localparam int PRIO_PASS_SCAN_LSB = 28;
  localparam int PRIO_FALLBACK_LSB = 28;
  localparam int STAT_TX_BIT = 0;
  localparam int STAT_RX_BIT = 1;
  localparam int STAT_TAG_LSB = 4;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10; // Clock period in ns.
  localparam int US_NS = 1000; // One microsecond in ns.
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_W = 7; // Holds CYC_PER_US - 1.
  localparam int TIME_W = 7; // Delay and duration field width.

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_EXCL_PWRUP = 2'b00,
    MODE_INCL_PWRUP = 2'b01,
    MODE_HIGH_PRIO = 2'b10,
    MODE_UNUSED = 2'b11
  } cxp_mode_t;

  typedef enum logic [3:0] {
    MSG_CONN_REQ = 4'h0,
    MSG_LINK_CTRL = 4'h1,
    MSG_DATA = 4'h2,
    MSG_INIT_SCAN = 4'h3,
    MSG_ACT_SCAN = 4'h4,
    MSG_CONN_ADV = 4'h5,
    MSG_NONCONN_ADV = 4'h6,
    MSG_PASS_SCAN = 4'h7
  } cxp_msg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_HOLD = 2'b10
  } cxp_tmr_st_t;

endpackage

/* File: include/cxp_dir_if.sv */
// Interface joining the top to one direction's priority timer.
`timescale 1ns/1ps
interface cxp_dir_if;
  logic coexistence_enable; // Interface enabled.
  logic en; // Transmit or receive enable of the radio.
  logic arm; // Direction is in high-priority indicator mode.
  logic above; // Current tag exceeds this direction's threshold.
  logic [6:0] delay; // Assert delay in microseconds.
  logic [6:0] dur; // Hold duration in microseconds, zero means open.
  logic prio; // Priority indication, from a flip-flop.
  modport ctl (output coexistence_enable, en, arm, above, delay, dur, input prio);
  modport tmr (input coexistence_enable, en, arm, above, delay, dur, output prio);
endinterface

/* File: rtl/cxp_prio_timer.sv */
// Delay and hold timer for one direction's priority indication.
`timescale 1ns/1ps
module cxp_prio_timer (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  cxp_dir_if.tmr t
);
  import cxp_pkg::*;

  // ****************************************************************
  // State and counters.
  // ****************************************************************
  cxp_tmr_st_t state_q, state_d; // Timer phase.
  logic en_q; // Enable one cycle ago, for edge detection.
  logic [CYC_W-1:0] cyc_q; // Cycles inside the current microsecond.
  logic [TIME_W-1:0] us_q; // Whole microseconds in the current phase.
  logic [TIME_W-1:0] dly_q; // Delay latched at the event start.
  logic [TIME_W-1:0] dur_q; // Duration latched at the event start.
  logic rise; // Enable has just risen.
  logic tick; // Last cycle of a microsecond.

  assign rise = t.en & ~en_q;
  assign tick = (cyc_q == CYC_W'(CYC_PER_US - 1));

  // Next phase; a disabled interface forces idle at once.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rise && t.arm && t.above) begin
          state_d = (t.delay == '0) ? ST_HOLD : ST_DELAY;
        end
      end
      ST_DELAY: begin
        // A radio event that ends early never raises priority.
        if (!t.en) begin
          state_d = ST_IDLE;
        end else if (tick && (us_q + 7'h01) == dly_q) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (dur_q == '0) begin
          if (!t.en) begin
            state_d = ST_IDLE;
          end
        end else if (tick && (us_q + 7'h01) == dur_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!t.coexistence_enable) begin
      state_d = ST_IDLE;
    end
  end

  // Phase register.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Enable history.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= t.en;
    end
  end

  // Delay and duration are sampled only when an event starts, so a write
  // to them during an event cannot stretch or cut it short.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      dly_q <= '0;
      dur_q <= '0;
    end else if (state_q == ST_IDLE && rise) begin
      dly_q <= t.delay;
      dur_q <= t.dur;
    end
  end

  // Microsecond counters restart at every change of phase.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || state_d != state_q) begin
      cyc_q <= '0;
      us_q <= '0;
    end else if (tick) begin
      cyc_q <= '0;
      us_q <= us_q + 7'h01;
    end else begin
      cyc_q <= cyc_q + 7'h01;
    end
  end

  // The indication is high exactly in the hold phase.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      t.prio <= 1'b0;
    end else begin
      t.prio <= (state_d == ST_HOLD);
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [15:0] since_rise_q; // Helper: cycles since the event start.
  logic [15:0] high_q; // Helper: cycles the indication has been high.

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || (state_q == ST_IDLE && rise)) begin
      since_rise_q <= '0;
    end else if (since_rise_q != 16'hFFFF) begin
      since_rise_q <= since_rise_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !t.prio) begin
      high_q <= '0;
    end else begin
      high_q <= high_q + 16'h0001;
    end
  end

  AST_OFF_WHEN_DISABLED: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !t.coexistence_enable |=> !t.prio)
    else $error("priority raised while interface disabled");

  AST_DELAY_EXACT: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(t.prio) |-> since_rise_q == dly_q * CYC_PER_US)
    else $error("priority rose at wrong delay");

  AST_DUR_EXACT: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $fell(t.prio) && $past(t.coexistence_enable) && dur_q != '0
      |-> $past(high_q) + 16'h0001 == dur_q * CYC_PER_US)
    else $error("priority held for wrong duration");

  AST_OPEN_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    t.prio && dur_q == '0 && t.en && t.coexistence_enable |=> t.prio)
    else $error("open hold dropped while enable high");

  AST_OPEN_RELEASE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    t.prio && dur_q == '0 && !t.en |=> !t.prio)
    else $error("open hold kept after enable fell");

  sequence s_start_qualified;
    $past(t.arm) && $past(t.above);
  endsequence

  AST_ONLY_ABOVE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(t.prio) && since_rise_q == 16'h0000 |-> s_start_qualified)
    else $error("priority raised without mode and threshold");

endmodule

/* File: rtl/cxp_coex_prio.sv */
// Coexistence priority signalling with its Wishbone register file.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module cxp_coex_prio (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_en_i,
  input wire logic rx_en_i,
  input wire cxp_pkg::cxp_msg_t msg_type_i,
  output logic [3:0] prio_tag_o,
  output logic tx_prio_o,
  output logic rx_prio_o
);
  import cxp_pkg::*;

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Merges bus write data into a register by byte lane, keeping
  // reserved bits at zero.
  function automatic logic [31:0] wb_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Picks the priority of a message type from the two maps.
  function automatic logic [3:0] pick_prio(
    input cxp_msg_t typ,
    input logic [31:0] map_a,
    input logic [31:0] map_b
  );
    logic [3:0] p;
    p = map_b[PRIO_FALLBACK_LSB +: 4];
    case (typ)
      MSG_PASS_SCAN: begin
        p = map_a[PRIO_PASS_SCAN_LSB +: 4];
      end
      MSG_NONCONN_ADV: begin
        p = map_a[PRIO_NONCONN_ADV_LSB +: 4];
      end
      MSG_CONN_ADV: begin
        p = map_a[PRIO_CONN_ADV_LSB +: 4];
      end
      MSG_ACT_SCAN: begin
        p = map_a[PRIO_ACT_SCAN_LSB +: 4];
      end
      MSG_INIT_SCAN: begin
        p = map_a[PRIO_INIT_SCAN_LSB +: 4];
      end
      MSG_DATA: begin
        p = map_a[PRIO_DATA_LSB +: 4];
      end
      MSG_LINK_CTRL: begin
        p = map_a[PRIO_LINK_CTRL_LSB +: 4];
      end
      MSG_CONN_REQ: begin
        p = map_a[PRIO_CONN_REQ_LSB +: 4];
      end
      default: begin
        p = map_b[PRIO_FALLBACK_LSB +: 4];
      end
    endcase
    return p;
  endfunction

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  logic [31:0] mode_ctrl_q; // Indication modes and enable.
  logic [31:0] timing_q; // Thresholds, duration and delay.
  logic [31:0] map_a_q; // Eight per-type priorities.
  logic [31:0] map_b_q; // Fallback priority.
  logic ack_q; // Bus acknowledge.
  logic [31:0] rdat_q; // Read data held for the bus.
  logic req; // A bus cycle is addressing this slave.
  logic wr_take; // The write takes effect at this edge.
  logic [31:0] rd_mux; // Read value for the current address.
  logic [31:0] status_w; // Live state as seen by software.
  logic [1:0] prio_vec; // Indications: index 0 transmit, 1 receive.

  assign req = wb_cyc_i & wb_stb_i;
  // The write lands on the edge where the master sees ack, so the
  // registers and the master agree on when it happened.
  assign wr_take = req & wb_we_i & ack_q;

  // Ack comes one cycle after the request and drops the cycle after,
  // so every access, mapped or not, is two cycles long.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Status: live indications and the current tag.
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[STAT_TX_BIT] = prio_vec[0];
    status_w[STAT_RX_BIT] = prio_vec[1];
    status_w[STAT_TAG_LSB +: 4] = prio_tag_o;
  end

  // Read decode; unmapped addresses read as zero.
  always_comb begin
    case (wb_adr_i)
      ADR_MODE_CTRL: begin
        rd_mux = mode_ctrl_q;
      end
      ADR_TIMING: begin
        rd_mux = timing_q;
      end
      ADR_MAP_A: begin
        rd_mux = map_a_q;
      end
      ADR_MAP_B: begin
        rd_mux = map_b_q;
      end
      ADR_STATUS: begin
        rd_mux = status_w;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured with the ack and held for its one cycle.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req & ~ack_q & ~wb_we_i) begin
      rdat_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************************************
  // Registers.
  // ****************************************************************

  // Mode and enable register; writes to the reserved bits are dropped.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mode_ctrl_q <= MODE_CTRL_RST;
    end else if (wr_take && wb_adr_i == ADR_MODE_CTRL) begin
      mode_ctrl_q <= wb_merge(mode_ctrl_q, wb_dat_i, wb_sel_i,
                              MODE_CTRL_MASK);
    end
  end

  // Thresholds and timing.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      timing_q <= TIMING_RST;
    end else if (wr_take && wb_adr_i == ADR_TIMING) begin
      timing_q <= wb_merge(timing_q, wb_dat_i, wb_sel_i, TIMING_MASK);
    end
  end

  // Per-type priority map.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      map_a_q <= MAP_A_RST;
    end else if (wr_take && wb_adr_i == ADR_MAP_A) begin
      map_a_q <= wb_merge(map_a_q, wb_dat_i, wb_sel_i, MAP_A_MASK);
    end
  end

  // Fallback priority map.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      map_b_q <= MAP_B_RST;
    end else if (wr_take && wb_adr_i == ADR_MAP_B) begin
      map_b_q <= wb_merge(map_b_q, wb_dat_i, wb_sel_i, MAP_B_MASK);
    end
  end

  // ****************************************************************
  // Priority tag and indications.
  // ****************************************************************
  logic [3:0] cur_tag; // Priority of the message type right now.

  assign cur_tag = pick_prio(msg_type_i, map_a_q, map_b_q);

  // Registered tag towards the arbiter; it follows the type with one
  // cycle of latency.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prio_tag_o <= 4'h0;
    end else begin
      prio_tag_o <= cur_tag;
    end
  end

  // One timer per direction. Only the high-priority indicator mode
  // is served here; the power-up indication modes leave it low.
  for (genvar g = 0; g < 2; g++) begin : gen_dir
    cxp_dir_if dir_if ();
    logic [4:0] thr; // This direction's threshold.
    cxp_mode_t mode; // This direction's indication mode.

    assign mode = cxp_mode_t'((g == 0) ? mode_ctrl_q[TX_MODE_LSB +: 2]
                                       : mode_ctrl_q[RX_MODE_LSB +: 2]);
    assign thr = (g == 0) ? timing_q[TX_THR_LSB +: 5]
                          : timing_q[RX_THR_LSB +: 5];
    assign dir_if.coexistence_enable = mode_ctrl_q[COEXISTENCE_ENABLE_BIT];
    assign dir_if.en = (g == 0) ? tx_en_i : rx_en_i;
    assign dir_if.arm = (mode == MODE_HIGH_PRIO);
    // The tag is compared with the live type so the decision is made
    // in the very cycle the enable rises.
    assign dir_if.above = {1'b0, cur_tag} > thr;
    assign dir_if.delay = timing_q[DELAY_LSB +: 7];
    assign dir_if.dur = timing_q[DUR_LSB +: 7];
    assign prio_vec[g] = dir_if.prio;

    cxp_prio_timer u_timer (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .t(dir_if.tmr)
    );
  end

  assign tx_prio_o = prio_vec[0];
  assign rx_prio_o = prio_vec[1];

  // ****************************************************************
  // Checks.
  // ****************************************************************
  AST_ACK_ONE_CYCLE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Judged at the first edge after release, so the unknown start-up
  // contents before the first reset edge never reach the check.
  AST_MAP_RESET: assert property (
    @(posedge ref_clk_i)
    $fell(sys_rst_i) |-> map_a_q == MAP_A_RST && map_b_q == MAP_B_RST)
    else $error("priority maps wrong after reset");

  AST_DATA_TAG: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    msg_type_i == MSG_DATA |=> prio_tag_o == $past(map_a_q[11:8]))
    else $error("data channel tag not taken from its field");

  AST_FALLBACK_TAG: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    msg_type_i[3] |=> prio_tag_o == $past(map_b_q[31:28]))
    else $error("unknown type did not use fallback priority");

  // A fresh request is one that the slave has not answered yet.
  sequence s_bus_new_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  AST_ACK_NEXT: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    s_bus_new_req |=> wb_ack_o)
    else $error("ack did not follow a new request");

  AST_PASS_SCAN_TAG: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    msg_type_i == MSG_PASS_SCAN |=> prio_tag_o == $past(map_a_q[31:28]))
    else $error("passive scan tag not taken from its field");

  AST_CONN_REQ_TAG: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    msg_type_i == MSG_CONN_REQ |=> prio_tag_o == $past(map_a_q[3:0]))
    else $error("connect request tag not taken from its field");

  // With the timer idle, a start outside indicator mode raises nothing.
  AST_TX_MODE_GATE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(tx_en_i) && !tx_prio_o
      && mode_ctrl_q[TX_MODE_LSB +: 2] != MODE_HIGH_PRIO |=> !tx_prio_o)
    else $error("tx indication raised outside indicator mode");

  AST_RX_MODE_GATE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(rx_en_i) && !rx_prio_o
      && mode_ctrl_q[RX_MODE_LSB +: 2] != MODE_HIGH_PRIO |=> !rx_prio_o)
    else $error("rx indication raised outside indicator mode");

  // Reserved bits must never hold a written one.
  AST_RESERVED_ZERO: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (mode_ctrl_q & ~MODE_CTRL_MASK) == 32'h0000_0000
      && (timing_q & ~TIMING_MASK) == 32'h0000_0000
      && (map_b_q & ~MAP_B_MASK) == 32'h0000_0000)
    else $error("reserved register bits set");

endmodule

/* File: test/cxp_arb_model.sv */
// Model of the coexistence arbiter that watches the priority indications.
`timescale 1ns/1ps
module cxp_arb_model (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] prio_i,
  output logic [1:0] done_o,
  output logic [1:0][15:0] len_o
);
  // Cycles counted while each indication is high.
  logic [1:0][15:0] cnt_q;

  // The arbiter only measures how long each grant request stands; it
  // never answers, since the block has no return path from the far side.
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      done_o[i] <= 1'b0;
      if (sys_rst_i) begin
        cnt_q[i] <= 16'h0000;
      end else if (prio_i[i]) begin
        cnt_q[i] <= cnt_q[i] + 16'h0001;
      end else if (cnt_q[i] != 16'h0000) begin
        // Falling edge seen: report the width and start over.
        done_o[i] <= 1'b1;
        len_o[i] <= cnt_q[i];
        cnt_q[i] <= 16'h0000;
      end
    end
  end
endmodule

/* File: test/tb_top.sv */
// Self-checking testbench of the coexistence priority block.
`timescale 1ns/1ps
module tb_top;
  import cxp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0000_0000, dat = 32'h0000_0000, rdat, ma, mb;
  logic [3:0] sel = 4'h0, tag;
  logic ack, tx_p, rx_p;
  logic [1:0] en = 2'b00, done;
  logic [1:0][15:0] len;
  cxp_msg_t msg = MSG_CONN_REQ;
  logic [31:0] seed = 32'd76271; // Fixed start of the xorshift sequence.
  int error_cnt = 0, checks = 0, e;
  logic [31:0] rd_q[$]; // Expected read data, oldest first.
  int pq[2][$]; // Expected pulse widths per direction (0 tx, 1 rx).

  cxp_coex_prio u_dut (.ref_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_en_i(en[0]),
    .rx_en_i(en[1]), .msg_type_i(msg), .prio_tag_o(tag), .tx_prio_o(tx_p),
    .rx_prio_o(rx_p));
  cxp_arb_model u_arb (.ref_clk_i(clk), .sys_rst_i(rst),
    .prio_i({rx_p, tx_p}), .done_o(done), .len_o(len));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, got);
    checks++;
    if (ex !== got) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic test_done();
    if (rd_q.size() != 0 || pq[0].size() != 0 || pq[1].size() != 0) begin
      error_cnt++;
      $display("BAD queues expected 0 seen %0d",
               rd_q.size() + pq[0].size() + pq[1].size());
    end
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [31:0] a, d,
                    input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      $display("BAD ack expected 1 seen 0");
      test_done();
    end
    cyc <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, ex);
    rd_q.push_back(ex);
    wb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  // Raise one enable for ln cycles; w is the expected pulse, 0 for none.
  task automatic ev(input int d, input int ln, input int w);
    if (w > 0) begin
      pq[d].push_back(w);
    end
    @(posedge clk);
    en[d] <= 1'b1;
    repeat (ln) @(posedge clk);
    en[d] <= 1'b0;
    repeat (w + 30) @(posedge clk);
  endtask

  // Read data is judged when ack appears, against the oldest note.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (rd_q.size() == 0) chk("read", 32'h0, 32'h1);
      else chk("read data", rd_q.pop_front(), rdat);
    end
    for (int i = 0; i < 2; i++) begin
      if (done[i] === 1'b1) begin
        if (pq[i].size() == 0) chk("unexpected pulse", 32'h0, 32'h1);
        else begin
          e = pq[i].pop_front();
          chk("pulse width", e, len[i]);
        end
      end
    end
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("BAD timeout expected 0 seen 1");
    test_done();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADR_MAP_A, MAP_A_RST);
    rd(ADR_MAP_B, MAP_B_RST);
    rd(ADR_TIMING, TIMING_RST);
    rd(ADR_MODE_CTRL, MODE_CTRL_RST);
    rd(ADR_STATUS, 32'h0000_00F0);
    rd(32'h4000_0200, 32'h0000_0000);
    $display("test reset done");
    // Random maps, read back, then the tag of every message type.
    ma = xs();
    mb = xs();
    wb(1'b1, ADR_MAP_A, ma, 4'hF);
    wb(1'b1, ADR_MAP_B, mb, 4'hF);
    rd(ADR_MAP_A, ma & MAP_A_MASK);
    rd(ADR_MAP_B, mb & MAP_B_MASK);
    for (int t = 0; t < 16; t++) begin
      @(posedge clk);
      msg <= cxp_msg_t'(t);
      repeat (2) @(posedge clk);
      #1 chk("tag", (t < 8) ? ma[4 * t +: 4] : mb[31:28], tag);
    end
    // Only byte lane 0 may change.
    mb = xs();
    wb(1'b1, ADR_TIMING, 32'hFFFF_FFFF, 4'hF);
    wb(1'b1, ADR_TIMING, mb, 4'h1);
    rd(ADR_TIMING, 32'h1F1F_7F00 | (mb & 32'h0000_007F));
    $display("test registers done");
    // Data priority D against tx threshold C: delay 1 us, hold 2 us.
    wb(1'b1, ADR_MAP_A, MAP_A_RST, 4'hF);
    @(posedge clk);
    msg <= MSG_DATA;
    wb(1'b1, ADR_MODE_CTRL, 32'h0022_0001, 4'hF);
    wb(1'b1, ADR_TIMING, 32'h0C0C_0201, 4'hF);
    pq[0].push_back(200);
    @(posedge clk);
    en[0] <= 1'b1;
    repeat (95) @(posedge clk);
    #1 chk("tx before delay", 1'b0, tx_p);
    repeat (10) @(posedge clk);
    #1 chk("tx after delay", 1'b1, tx_p);
    rd(ADR_STATUS, 32'h0000_00D1);
    @(posedge clk);
    en[0] <= 1'b0;
    repeat (240) @(posedge clk);
    wb(1'b1, ADR_TIMING, 32'h0C0D_0201, 4'hF);
    ev(0, 150, 0);
    // Rx with no delay and open duration: stands while enable stays high.
    wb(1'b1, ADR_TIMING, 32'h0C0D_0000, 4'hF);
    ev(1, 60, 60);
    $display("test indication done");
    // Only mode 10 raises the indication; a cleared enable bit never does.
    wb(1'b1, ADR_TIMING, 32'h0C0C_0101, 4'hF);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, ADR_MODE_CTRL, 32'h0000_0001 | (m << 16), 4'hF);
      ev(0, 120, (m == 2) ? 100 : 0);
    end
    wb(1'b1, ADR_MODE_CTRL, 32'h0022_0000, 4'hF);
    ev(0, 20, 0);
    ev(1, 20, 0);
    $display("test modes done");
    repeat (5) @(posedge clk);
    test_done();
  end
endmodule
